// [rtl/counter_array_pkg.sv]
package counter_array_pkg;

  // ==========================================
  // Register byte offsets
  localparam logic [5:0] OFS_CONTROL = 6'h00;
  localparam logic [5:0] OFS_MODE = 6'h04;
  localparam logic [5:0] OFS_COUNT_LOW = 6'h08;
  localparam logic [5:0] OFS_COUNT_HIGH = 6'h0c;
  localparam logic [5:0] OFS_MOD0_MODE = 6'h10;
  localparam logic [5:0] OFS_MOD0_CMP_LOW = 6'h14;
  localparam logic [5:0] OFS_MOD0_CMP_HIGH = 6'h18;
  localparam logic [5:0] OFS_WDT_OFFSET = 6'h1c;
  localparam logic [5:0] OFS_WDT_CMP_HIGH = 6'h20;

  // ==========================================
  // Control register fields
  localparam int CTL_OVF_BIT = 7;
  localparam int CTL_WDT_FLAG_BIT = 5;
  localparam int CTL_MOD0_FLAG_BIT = 0;

  // ==========================================
  // Counter mode register fields
  localparam int MODE_IDLE_BIT = 7;
  localparam int MODE_WDT_EN_BIT = 6;
  localparam int MODE_LOCK_BIT = 5;
  localparam int MODE_SEL_LSB = 1;
  localparam logic [7:0] MODE_RESET = 8'h40;

  // ==========================================
  // Module mode register fields
  localparam int MOD_CMP_EN_BIT = 6;
  localparam int MOD_TOG_EN_BIT = 2;
  localparam int MOD_PW_EN_BIT = 1;
  localparam logic [7:0] MOD_MODE_RESET = 8'h00;

  // ==========================================
  // Counter clock selection and prescaler counts
  localparam logic [2:0] SEL_DIV12 = 3'h0;
  localparam logic [2:0] SEL_DIV4 = 3'h1;
  localparam logic [2:0] SEL_TIMER = 3'h2;
  localparam logic [2:0] SEL_EXT = 3'h3;
  localparam logic [2:0] SEL_SYS = 3'h4;
  localparam logic [3:0] DIV12_LAST = 4'hb;
  localparam logic [1:0] DIV4_LAST = 2'h3;

  // ==========================================
  // Byte values
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_FULL = 8'hff;

endpackage : counter_array_pkg

// [rtl/counter_array_wdt.sv]
`timescale 1ns/1ps

// Contract
// - Square wave toggles pin every compare-high count; frequency is clock over twice it.
// - Compare high of zero acts as a half period of 256 counter clocks.
// - Compare low matched to counter low toggles pin and adds high byte.
// - Square wave runs only with compare, toggle and pulse-width enables all set.
// - Writing compare low clears compare enable; writing compare high sets it.
// - Three-bit clock select in counter mode register picks the counter clock.
// - Watchdog compare high byte is compared with counter high byte.
// - Watchdog offset counts low-byte overflows allowed after reload.
// - Watchdog reset when low byte overflows while compare high equals counter high.
// - Writing one to watchdog flag while enabled forces immediate watchdog reset.
// - Any write to watchdog compare high reloads and restarts the timeout.
// - With watchdog enabled, clock select and idle-suspend writes are ignored.
// - Watchdog enabled when enable bit or lock bit is set.
// - Lock holds watchdog enabled until reset; otherwise clearing enable disables it.
// - Reset enables watchdog, selects clock over 12, zeroes counter low and offset.
// - Idle-suspend set stops counter and watchdog while processor idles.

module counter_array_wdt (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic idle_i,
  input wire logic timer_ovf_i,
  input wire logic ext_tick_i,
  output logic module_output_pin_o,
  output logic wdt_reset_o
);

  // ==========================================
  // State
  logic [7:0] counter_mode_register_r;
  logic [7:0] counter_mode_register_nxt;
  logic [7:0] counter_low_byte_r;
  logic [7:0] counter_low_byte_nxt;
  logic [7:0] counter_high_byte_r;
  logic [7:0] counter_high_byte_nxt;
  logic [7:0] mod0_mode_r;
  logic [7:0] mod0_mode_nxt;
  logic [7:0] compare_low_byte_r;
  logic [7:0] compare_low_byte_nxt;
  logic [7:0] compare_high_byte_r;
  logic [7:0] watchdog_offset_r;
  logic [7:0] watchdog_compare_high_r;
  logic [7:0] watchdog_compare_high_nxt;
  logic ovf_flag_r;
  logic ovf_flag_nxt;
  logic mod0_flag_r;
  logic mod0_flag_nxt;
  logic wdt_reset_r;
  logic wdt_reset_nxt;
  logic waitrequest_r;
  logic waitrequest_nxt;
  logic [31:0] readdata_r;

  // ==========================================
  // Bus decode
  // Each access waits one cycle so read data are registered before the accept edge
  logic req;
  logic accept;
  logic wr_ok;
  logic wr_control;
  logic wr_mode;
  logic wr_count_low;
  logic wr_count_high;
  logic wr_mod0_mode;
  logic wr_cmp_low;
  logic wr_cmp_high;
  logic wr_wdt_offset;
  logic wr_wdt_cmp_high;
  logic [7:0] wdata;

  assign req = avs_read_i | avs_write_i;
  assign accept = req & ~waitrequest_r;
  assign wr_ok = accept & avs_write_i & avs_byteenable_i[0];
  assign wdata = avs_writedata_i[7:0];
  assign wr_control = wr_ok & (avs_address_i == counter_array_pkg::OFS_CONTROL);
  assign wr_mode = wr_ok & (avs_address_i == counter_array_pkg::OFS_MODE);
  assign wr_count_low = wr_ok & (avs_address_i == counter_array_pkg::OFS_COUNT_LOW);
  assign wr_count_high = wr_ok & (avs_address_i == counter_array_pkg::OFS_COUNT_HIGH);
  assign wr_mod0_mode = wr_ok & (avs_address_i == counter_array_pkg::OFS_MOD0_MODE);
  assign wr_cmp_low = wr_ok & (avs_address_i == counter_array_pkg::OFS_MOD0_CMP_LOW);
  assign wr_cmp_high = wr_ok & (avs_address_i == counter_array_pkg::OFS_MOD0_CMP_HIGH);
  assign wr_wdt_offset = wr_ok & (avs_address_i == counter_array_pkg::OFS_WDT_OFFSET);
  assign wr_wdt_cmp_high = wr_ok & (avs_address_i == counter_array_pkg::OFS_WDT_CMP_HIGH);

  // ==========================================
  // Mode register fields
  logic idle_suspend_bit;
  logic watchdog_enable_bit;
  logic watchdog_lock_bit;
  logic [2:0] counter_clock_select;
  logic wdt_enabled;

  assign idle_suspend_bit = counter_mode_register_r[counter_array_pkg::MODE_IDLE_BIT];
  assign watchdog_enable_bit = counter_mode_register_r[counter_array_pkg::MODE_WDT_EN_BIT];
  assign watchdog_lock_bit = counter_mode_register_r[counter_array_pkg::MODE_LOCK_BIT];
  assign counter_clock_select =
    counter_mode_register_r[counter_array_pkg::MODE_SEL_LSB +: 3];
  assign wdt_enabled = watchdog_enable_bit | watchdog_lock_bit;

  // ==========================================
  // Mode register update
  logic [7:0] mode_wr_val;

  always_comb begin
    mode_wr_val = wdata;
    mode_wr_val[0] = 1'b0;
    mode_wr_val[4] = 1'b0;
    // Lock is sticky: a write can set it but never clear it
    mode_wr_val[counter_array_pkg::MODE_LOCK_BIT] = wdata[counter_array_pkg::MODE_LOCK_BIT]
      | watchdog_lock_bit;
    if (wdt_enabled) begin
      mode_wr_val[counter_array_pkg::MODE_IDLE_BIT] = idle_suspend_bit;
      mode_wr_val[counter_array_pkg::MODE_SEL_LSB +: 3] = counter_clock_select;
    end
  end

  assign counter_mode_register_nxt = wr_mode ? mode_wr_val : counter_mode_register_r;

  // ==========================================
  // Counter clock and counter
  logic tick;
  logic count_en;
  logic low_wrap;
  logic low_ovf;
  logic [7:0] count_low_inc;

  counter_tick_gen u_tick_gen (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .sel_i(counter_clock_select),
    .timer_ovf_i(timer_ovf_i),
    .ext_tick_i(ext_tick_i),
    .tick_o(tick)
  );

  assign count_en = tick & ~(idle_suspend_bit & idle_i);
  assign low_wrap = (counter_low_byte_r == counter_array_pkg::BYTE_FULL);
  assign low_ovf = count_en & low_wrap;
  assign count_low_inc = counter_low_byte_r + 8'h01;

  // A software write to a counter byte wins over the tick in that cycle
  assign counter_low_byte_nxt = wr_count_low ? wdata
    : (count_en ? count_low_inc : counter_low_byte_r);
  assign counter_high_byte_nxt = wr_count_high ? wdata
    : (low_ovf ? counter_high_byte_r + 8'h01 : counter_high_byte_r);

  // ==========================================
  // Square-wave module
  logic sq_active;
  logic sq_match;
  logic sq_pin;

  assign sq_active = mod0_mode_r[counter_array_pkg::MOD_CMP_EN_BIT]
    & mod0_mode_r[counter_array_pkg::MOD_TOG_EN_BIT]
    & mod0_mode_r[counter_array_pkg::MOD_PW_EN_BIT];

  square_wave_out u_square (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .active_i(sq_active),
    .count_en_i(count_en),
    .count_low_nxt_i(count_low_inc),
    .cmp_low_i(compare_low_byte_r),
    .match_o(sq_match),
    .pin_o(sq_pin)
  );

  // Adding a zero high byte leaves the compare unchanged: next match is 256 clocks on
  assign compare_low_byte_nxt = wr_cmp_low ? wdata
    : (sq_match ? compare_low_byte_r + compare_high_byte_r : compare_low_byte_r);

  always_comb begin
    mod0_mode_nxt = wr_mod0_mode ? wdata : mod0_mode_r;
    if (wr_cmp_low) begin
      mod0_mode_nxt[counter_array_pkg::MOD_CMP_EN_BIT] = 1'b0;
    end
    if (wr_cmp_high) begin
      mod0_mode_nxt[counter_array_pkg::MOD_CMP_EN_BIT] = 1'b1;
    end
  end

  // ==========================================
  // Watchdog
  // A reload places the compare point offset high-byte steps ahead of the counter
  logic wdt_match;
  logic wdt_timeout;
  logic wdt_force;

  assign watchdog_compare_high_nxt = wr_wdt_cmp_high
    ? counter_high_byte_r + watchdog_offset_r : watchdog_compare_high_r;
  assign wdt_match = (watchdog_compare_high_r == counter_high_byte_r);
  assign wdt_timeout = wdt_enabled & low_ovf & wdt_match;
  assign wdt_force = wr_control & wdata[counter_array_pkg::CTL_WDT_FLAG_BIT] & wdt_enabled;
  // Events in back-to-back cycles merge, so the reset logic never sees a two-cycle level
  assign wdt_reset_nxt = (wdt_timeout | wdt_force) & ~wdt_reset_r;

  // ==========================================
  // Status flags: hardware set wins over a software clear
  logic count_wrap;

  assign count_wrap = low_ovf & (counter_high_byte_r == counter_array_pkg::BYTE_FULL);
  assign ovf_flag_nxt = count_wrap ? 1'b1
    : (wr_control ? wdata[counter_array_pkg::CTL_OVF_BIT] & ovf_flag_r : ovf_flag_r);
  assign mod0_flag_nxt = sq_match ? 1'b1
    : (wr_control ? wdata[counter_array_pkg::CTL_MOD0_FLAG_BIT] & mod0_flag_r : mod0_flag_r);

  // ==========================================
  // Read mux
  logic [7:0] rd_byte;

  always_comb begin
    rd_byte = counter_array_pkg::BYTE_ZERO;
    unique case (avs_address_i)
      counter_array_pkg::OFS_CONTROL: begin
        rd_byte[counter_array_pkg::CTL_OVF_BIT] = ovf_flag_r;
        rd_byte[counter_array_pkg::CTL_MOD0_FLAG_BIT] = mod0_flag_r;
      end
      counter_array_pkg::OFS_MODE: rd_byte = counter_mode_register_r;
      counter_array_pkg::OFS_COUNT_LOW: rd_byte = counter_low_byte_r;
      counter_array_pkg::OFS_COUNT_HIGH: rd_byte = counter_high_byte_r;
      counter_array_pkg::OFS_MOD0_MODE: rd_byte = mod0_mode_r;
      counter_array_pkg::OFS_MOD0_CMP_LOW: rd_byte = compare_low_byte_r;
      counter_array_pkg::OFS_MOD0_CMP_HIGH: rd_byte = compare_high_byte_r;
      counter_array_pkg::OFS_WDT_OFFSET: rd_byte = watchdog_offset_r;
      counter_array_pkg::OFS_WDT_CMP_HIGH: rd_byte = watchdog_compare_high_r;
      default: rd_byte = counter_array_pkg::BYTE_ZERO;
    endcase
  end

  assign waitrequest_nxt = accept | ~req;

  // ==========================================
  // Registers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      counter_mode_register_r <= counter_array_pkg::MODE_RESET;
      counter_low_byte_r <= counter_array_pkg::BYTE_ZERO;
      counter_high_byte_r <= counter_array_pkg::BYTE_ZERO;
      ovf_flag_r <= 1'b0;
    end else begin
      counter_mode_register_r <= counter_mode_register_nxt;
      counter_low_byte_r <= counter_low_byte_nxt;
      counter_high_byte_r <= counter_high_byte_nxt;
      ovf_flag_r <= ovf_flag_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      mod0_mode_r <= counter_array_pkg::MOD_MODE_RESET;
      compare_low_byte_r <= counter_array_pkg::BYTE_ZERO;
      compare_high_byte_r <= counter_array_pkg::BYTE_ZERO;
      mod0_flag_r <= 1'b0;
    end else begin
      mod0_mode_r <= mod0_mode_nxt;
      compare_low_byte_r <= compare_low_byte_nxt;
      if (wr_cmp_high) begin
        compare_high_byte_r <= wdata;
      end
      mod0_flag_r <= mod0_flag_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      watchdog_offset_r <= counter_array_pkg::BYTE_ZERO;
      watchdog_compare_high_r <= counter_array_pkg::BYTE_ZERO;
      wdt_reset_r <= 1'b0;
    end else begin
      if (wr_wdt_offset) begin
        watchdog_offset_r <= wdata;
      end
      watchdog_compare_high_r <= watchdog_compare_high_nxt;
      wdt_reset_r <= wdt_reset_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      waitrequest_r <= 1'b1;
      readdata_r <= 32'h0000_0000;
    end else begin
      waitrequest_r <= waitrequest_nxt;
      readdata_r <= {24'h00_0000, rd_byte};
    end
  end

  // ==========================================
  // Outputs
  // The pin flop lives in the square-wave module
  assign module_output_pin_o = sq_pin;
  assign wdt_reset_o = wdt_reset_r;
  assign avs_readdata_o = readdata_r;
  assign avs_waitrequest_o = waitrequest_r;

endmodule : counter_array_wdt

// [rtl/counter_tick_gen.sv]
`timescale 1ns/1ps

module counter_tick_gen (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [2:0] sel_i,
  input wire logic timer_ovf_i,
  input wire logic ext_tick_i,
  output logic tick_o
);

  // ==========================================
  // Prescalers run free so a new selection takes effect at once
  logic [3:0] div12_r;
  logic [3:0] div12_nxt;
  logic [1:0] div4_r;
  logic [1:0] div4_nxt;
  logic div12_wrap;
  logic div4_wrap;

  assign div12_wrap = (div12_r == counter_array_pkg::DIV12_LAST);
  assign div4_wrap = (div4_r == counter_array_pkg::DIV4_LAST);
  assign div12_nxt = div12_wrap ? 4'h0 : div12_r + 4'h1;
  assign div4_nxt = div4_r + 2'h1;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      div12_r <= 4'h0;
      div4_r <= 2'h0;
    end else begin
      div12_r <= div12_nxt;
      div4_r <= div4_nxt;
    end
  end

  // ==========================================
  // Source selection
  always_comb begin
    unique case (sel_i)
      counter_array_pkg::SEL_DIV4: tick_o = div4_wrap;
      counter_array_pkg::SEL_TIMER: tick_o = timer_ovf_i;
      counter_array_pkg::SEL_EXT: tick_o = ext_tick_i;
      counter_array_pkg::SEL_SYS: tick_o = 1'b1;
      default: tick_o = div12_wrap;
    endcase
  end

endmodule : counter_tick_gen

// [rtl/square_wave_out.sv]
`timescale 1ns/1ps

module square_wave_out (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic active_i,
  input wire logic count_en_i,
  input wire logic [7:0] count_low_nxt_i,
  input wire logic [7:0] cmp_low_i,
  output logic match_o,
  output logic pin_o
);

  logic pin_r;

  // Compare against the value the counter takes at this tick
  assign match_o = active_i & count_en_i & (count_low_nxt_i == cmp_low_i);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pin_r <= 1'b0;
    end else if (match_o) begin
      pin_r <= ~pin_r;
    end
  end

  assign pin_o = pin_r;

endmodule : square_wave_out

// [tb/counter_array_wdt_bench.sv]
`timescale 1ns/1ps

module counter_array_wdt_bench;
  logic clk_i;
  logic rst_n_i;
  logic [5:0] avs_address_i;
  logic avs_read_i;
  logic avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic idle_i;
  logic timer_ovf_i;
  logic ext_tick_i;
  logic module_output_pin_o;
  logic wdt_reset_o;
  int errors;
  int comparisons;
  int pulses;
  int n;
  logic [15:0] q;
  logic [15:0] q0;

  // Tick inputs pulse only in the clock-select scenario; elsewhere sysclk gives exact counts
  counter_array_wdt DUT (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(4'hf), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .idle_i(idle_i), .timer_ovf_i(timer_ovf_i),
    .ext_tick_i(ext_tick_i), .module_output_pin_o(module_output_pin_o),
    .wdt_reset_o(wdt_reset_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    if (wdt_reset_o === 1'b1) begin
      pulses <= pulses + 1;
    end
  end

  // ==========================================
  // Tasks
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic print_verdict();
    if (errors == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict

  task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] dat);
    int k;
    k = 0;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= {24'h000000, dat};
    avs_write_i <= wr;
    avs_read_i <= ~wr;
    do begin
      @(posedge clk_i);
      k++;
    end while (avs_waitrequest_o !== 1'b0 && k < 50);
    q = {8'h00, avs_readdata_o[7:0]};
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    if (avs_waitrequest_o !== 1'b0) begin
      errors++;
      print_verdict();
    end
  endtask : bus

  task automatic gap(input int lim, input logic hold);
    logic p;
    p = module_output_pin_o;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (module_output_pin_o === p && n < lim);
    if (n >= lim && !hold) begin
      errors++;
      print_verdict();
    end
  endtask : gap

  // Counter advance over 4 + 2 * m edges, with m pulses on both tick inputs
  task automatic step(input logic [7:0] mode, input int m, input logic [15:0] exp);
    bus(1'b1, counter_array_pkg::OFS_MODE, mode);
    bus(1'b0, counter_array_pkg::OFS_COUNT_LOW, 8'h00);
    q0 = q;
    repeat (m) begin
      @(posedge clk_i);
      timer_ovf_i <= 1'b1;
      ext_tick_i <= 1'b1;
      @(posedge clk_i);
      timer_ovf_i <= 1'b0;
      ext_tick_i <= 1'b0;
    end
    @(posedge clk_i);
    bus(1'b0, counter_array_pkg::OFS_COUNT_LOW, 8'h00);
    check((q - q0) & 16'h00ff, exp, "clock select");
  endtask : step

  // ==========================================
  // Main sequence
  initial begin
    rst_n_i = 1'b0;
    avs_address_i = 6'h00;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h00000000;
    idle_i = 1'b0;
    timer_ovf_i = 1'b0;
    ext_tick_i = 1'b0;
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    bus(1'b0, counter_array_pkg::OFS_MODE, 8'h00);
    check(q, 16'h0040, "mode");
    bus(1'b0, counter_array_pkg::OFS_WDT_OFFSET, 8'h00);
    check(q, 16'h0000, "offset");
    bus(1'b0, 6'h3c, 8'h00);
    check(q, 16'h0000, "unmapped");
    bus(1'b1, counter_array_pkg::OFS_MODE, 8'h00);
    bus(1'b1, counter_array_pkg::OFS_MODE, 8'h08);
    bus(1'b0, counter_array_pkg::OFS_MODE, 8'h00);
    check(q, 16'h0008, "mode");
    q0 = 16'(pulses);
    bus(1'b1, counter_array_pkg::OFS_CONTROL, 8'h20);
    repeat (20) @(posedge clk_i);
    check(16'(pulses), q0, "disabled force");
    bus(1'b1, counter_array_pkg::OFS_MOD0_MODE, 8'h46);
    bus(1'b1, counter_array_pkg::OFS_MOD0_CMP_LOW, 8'h00);
    bus(1'b0, counter_array_pkg::OFS_MOD0_MODE, 8'h00);
    check(q, 16'h0006, "module mode");
    bus(1'b1, counter_array_pkg::OFS_MOD0_CMP_HIGH, 8'h04);
    bus(1'b0, counter_array_pkg::OFS_MOD0_MODE, 8'h00);
    check(q, 16'h0046, "module mode");
    repeat (2) gap(600, 1'b0);
    check(16'(n), 16'h0004, "half period");
    bus(1'b1, counter_array_pkg::OFS_MOD0_CMP_HIGH, 8'h00);
    repeat (3) gap(600, 1'b0);
    check(16'(n), 16'h0100, "half period");
    bus(1'b1, counter_array_pkg::OFS_MOD0_MODE, 8'h44);
    gap(600, 1'b1);
    check(16'(n), 16'h0258, "pin held");
    bus(1'b1, counter_array_pkg::OFS_MODE, 8'h88);
    idle_i <= 1'b1;
    bus(1'b0, counter_array_pkg::OFS_COUNT_LOW, 8'h00);
    q0 = q;
    bus(1'b0, counter_array_pkg::OFS_COUNT_LOW, 8'h00);
    check(q, q0, "idle count");
    idle_i <= 1'b0;
    bus(1'b0, counter_array_pkg::OFS_COUNT_LOW, 8'h00);
    q0 = q;
    bus(1'b0, counter_array_pkg::OFS_COUNT_LOW, 8'h00);
    check((q - q0) & 16'h00ff, 16'h0003, "count step");
    step(8'h02, 18, 16'h000a);
    step(8'h00, 16, 16'h0003);
    step(8'h04, 7, 16'h0007);
    step(8'h06, 5, 16'h0005);
    bus(1'b1, counter_array_pkg::OFS_MODE, 8'h08);
    bus(1'b1, counter_array_pkg::OFS_WDT_OFFSET, 8'h01);
    bus(1'b1, counter_array_pkg::OFS_MODE, 8'h48);
    bus(1'b1, counter_array_pkg::OFS_MODE, 8'h40);
    bus(1'b0, counter_array_pkg::OFS_MODE, 8'h00);
    check(q, 16'h0048, "mode");
    // Snapshot after the first reload: the reset compare value could fire earlier
    bus(1'b1, counter_array_pkg::OFS_WDT_CMP_HIGH, 8'h00);
    q0 = 16'(pulses);
    repeat (3) begin
      repeat (200) @(posedge clk_i);
      bus(1'b1, counter_array_pkg::OFS_WDT_CMP_HIGH, 8'h00);
    end
    check(16'(pulses), q0, "reloaded");
    n = 0;
    while (pulses == int'(q0) && n < 700) begin
      @(posedge clk_i);
      n++;
    end
    check(16'(n >= 255 && n <= 516), 16'h0001, "timeout");
    if (n >= 700) begin
      print_verdict();
    end
    q0 = 16'(pulses);
    bus(1'b1, counter_array_pkg::OFS_CONTROL, 8'h20);
    repeat (4) @(posedge clk_i);
    check(16'(pulses), q0 + 16'h0001, "forced");
    bus(1'b1, counter_array_pkg::OFS_MODE, 8'h28);
    bus(1'b1, counter_array_pkg::OFS_MODE, 8'h00);
    bus(1'b0, counter_array_pkg::OFS_MODE, 8'h00);
    check(q, 16'h0028, "locked mode");
    q0 = 16'(pulses);
    bus(1'b1, counter_array_pkg::OFS_CONTROL, 8'h20);
    repeat (4) @(posedge clk_i);
    check(16'(pulses), q0 + 16'h0001, "locked force");
    print_verdict();
  end
endmodule : counter_array_wdt_bench

// [tb/counter_array_wdt_checker.sv]
`timescale 1ns/1ps

module counter_array_wdt_checker (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic idle_i,
  input wire logic timer_ovf_i,
  input wire logic ext_tick_i,
  input wire logic module_output_pin_o,
  input wire logic wdt_reset_o
);
  // ==========================================
  // Shadow state rebuilt from accepted writes, since bodies are hidden
  logic wr_ok;
  logic en_r;
  logic lock_r;
  logic [2:0] mod_r;
  logic active;
  logic [7:0] d;
  assign d = avs_writedata_i[7:0];
  assign wr_ok = avs_write_i & ~avs_waitrequest_o & avs_byteenable_i[0];
  assign active = &mod_r;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      en_r <= 1'b1;
      lock_r <= 1'b0;
      mod_r <= 3'h0;
    end else if (wr_ok) begin
      if (avs_address_i == counter_array_pkg::OFS_MODE) begin
        en_r <= d[6] | d[5] | lock_r;
        lock_r <= lock_r | d[5];
      end
      if (avs_address_i == counter_array_pkg::OFS_MOD0_MODE) begin
        mod_r <= {d[6], d[2], d[1]};
      end
      if (avs_address_i == counter_array_pkg::OFS_MOD0_CMP_LOW) begin
        mod_r[2] <= 1'b0;
      end
      if (avs_address_i == counter_array_pkg::OFS_MOD0_CMP_HIGH) begin
        mod_r[2] <= 1'b1;
      end
    end
  end

  // ==========================================
  // Properties
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence force_wr;
    wr_ok && avs_address_i == counter_array_pkg::OFS_CONTROL && d[5] && en_r;
  endsequence
  a_wait_one_cycle: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  a_wait_bounded: assert property ((avs_read_i || avs_write_i) |-> ##[0:1] !avs_waitrequest_o)
    else $error("request not accepted in time");
  a_accept_needs_req: assert property (!avs_waitrequest_o |-> (avs_read_i || avs_write_i))
    else $error("accept without request");
  a_read_upper_zero: assert property (avs_readdata_o[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  a_reset_single_pulse: assert property (wdt_reset_o |=> !wdt_reset_o)
    else $error("watchdog reset longer than one cycle");
  a_force_reset: assert property (force_wr |-> ##[1:2] wdt_reset_o)
    else $error("forced watchdog reset missing");
  a_disabled_quiet: assert property ((!en_r && !$past(en_r)) |-> !wdt_reset_o)
    else $error("watchdog reset while disabled");
  a_pin_hold: assert property ((!active && !$past(active)) |-> $stable(module_output_pin_o))
    else $error("output pin moved while inactive");
endmodule : counter_array_wdt_checker

bind counter_array_wdt counter_array_wdt_checker chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .idle_i(idle_i), .timer_ovf_i(timer_ovf_i),
  .ext_tick_i(ext_tick_i), .module_output_pin_o(module_output_pin_o),
  .wdt_reset_o(wdt_reset_o)
);
